/* lrop_pkg.sv */
// constants, word type and behaviour summary for the line receive output port
// Operation
// - Mode picks negative-rail output meaning: negative marks (dual) or violations (single).
// - Dual-rail: positive marks on positive rail, negative marks on negative rail only.
// - Dual-rail: negative rail high one recovered-clock period per negative pulse.
// - Single-rail: violation output high at least one period per violation or zero run.
// - Recovered clock is output; rails change only on its rising edge or when they clear to 0 as the output goes idle.
// - Single-rail: violation output also changes only on recovered-clock rising edge or when the output goes idle.
// - Plus input above minus is a positive mark; below is a negative mark.
// - Single-rail: all received data serially on positive rail, one bit per period.
// - Dual-rail: positive rail high one recovered-clock period per positive pulse.
package lrop_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OUT_PERIOD_NS = 32;
  localparam int OUT_DIV = (OUT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_HIGH = OUT_DIV / 2;
  localparam int EXZ_LIMIT = 3;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_W = 4;
  localparam int SYNC_CLK = 0;
  localparam int SYNC_PLUS = 1;
  localparam int SYNC_MINUS = 2;
  localparam int SYNC_MODE = 3;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h0;

  typedef struct packed {
    logic pos;
    logic neg;
    logic viol;
  } lrop_word_t;

  localparam lrop_word_t WORD_IDLE = 3'h0;
endpackage : lrop_pkg

/* lrop_rx.sv */
// line receive output port: line sampler, violation detector, two-entry buffer, rail output
`timescale 1ns/100ps
module lrop_rx
  import lrop_pkg::*;
#(
  parameter int DIV = OUT_DIV,
  parameter int EXCESS_ZERO_EVENT = EXZ_LIMIT,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic line_clk,
  input wire logic line_input_plus,
  input wire logic line_input_minus,
  input wire logic single_rail_mode,
  input wire logic out_ready,
  output logic in_ready_out,
  output logic recovered_clock_out,
  output logic positive_rail_out,
  output logic neg_rail_or_violation_out
);
  localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int ZW = $clog2(EXCESS_ZERO_EVENT + 1);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the line clock, line data and mode pins
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] pin_in;
  logic line_clk_d_r;

  assign pin_in = {single_rail_mode, line_input_minus, line_input_plus, line_clk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[gi] <= SYNC_RESET[gi];
          sync2_r[gi] <= SYNC_RESET[gi];
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_clk_d_r <= 1'b0;
    end else begin
      line_clk_d_r <= sync2_r[SYNC_CLK];
    end
  end

  logic bit_edge;
  logic mark_pos;
  logic mark_neg;
  logic mark_both;
  logic mode_single;

  assign bit_edge = sync2_r[SYNC_CLK] & ~line_clk_d_r;
  assign mark_pos = sync2_r[SYNC_PLUS] & ~sync2_r[SYNC_MINUS];
  assign mark_neg = sync2_r[SYNC_MINUS] & ~sync2_r[SYNC_PLUS];
  assign mark_both = sync2_r[SYNC_PLUS] & sync2_r[SYNC_MINUS];
  assign mode_single = sync2_r[SYNC_MODE];

  ////////////////////////////////////////////////////////////////////////////
  // violation and excessive-zero detection, no decoder: substitutions flag too
  logic last_neg_r;
  logic seen_mark_r;
  logic [ZW-1:0] zero_cnt_r;
  logic bpv;
  logic excess_zero_event;
  lrop_word_t wr_word;

  assign bpv = mark_both | (seen_mark_r & ((mark_pos & ~last_neg_r) | (mark_neg & last_neg_r)));
  assign excess_zero_event = ~mark_pos & ~mark_neg & ~mark_both & (zero_cnt_r == ZW'(EXCESS_ZERO_EVENT - 1));
  assign wr_word = '{pos: mark_pos, neg: mark_neg, viol: bpv | excess_zero_event};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_neg_r <= 1'b0;
      seen_mark_r <= 1'b0;
      zero_cnt_r <= '0;
    end else if (bit_edge) begin
      if (mark_pos | mark_neg) begin
        last_neg_r <= mark_neg;
        seen_mark_r <= 1'b1;
      end
      if (mark_pos | mark_neg | mark_both) begin
        zero_cnt_r <= '0;
      end else if (zero_cnt_r != ZW'(EXCESS_ZERO_EVENT)) begin
        zero_cnt_r <= zero_cnt_r + ZW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer; a word arriving while full is dropped, in_ready_out warns
  lrop_word_t mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic push;
  logic pop;
  logic slot_free;
  logic busy_r;
  logic [PW-1:0] phase_r;
  logic phase_end;
  lrop_word_t rd_word;

  assign rd_word = mem_r[rd_ptr_r];
  assign slot_free = (count_r != CW'(DEPTH));
  assign push = bit_edge & slot_free;
  assign phase_end = ~busy_r | (phase_r == PW'(DIV - 1));
  assign pop = phase_end & (count_r != '0) & out_ready;
  assign count_nxt = count_r + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      in_ready_out <= (count_nxt != CW'(DEPTH));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail output: gapped clock, rising edge carries the new bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      phase_r <= '0;
      recovered_clock_out <= 1'b0;
      positive_rail_out <= 1'b0;
      neg_rail_or_violation_out <= 1'b0;
    end else if (phase_end) begin
      phase_r <= '0;
      if (pop) begin
        busy_r <= 1'b1;
        recovered_clock_out <= 1'b1;
        positive_rail_out <= mode_single ? (rd_word.pos | rd_word.neg) : rd_word.pos;
        neg_rail_or_violation_out <= mode_single ? rd_word.viol : rd_word.neg;
      end else begin
        busy_r <= 1'b0;
        recovered_clock_out <= 1'b0;
        positive_rail_out <= 1'b0;
        neg_rail_or_violation_out <= 1'b0;
      end
    end else begin
      phase_r <= phase_r + PW'(1);
      if (phase_r == PW'(OUT_HIGH - 1)) begin
        recovered_clock_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  mode_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pop |=> neg_rail_or_violation_out == ($past(mode_single) ? $past(rd_word.viol) : $past(rd_word.neg)))
    else $error("negative rail meaning does not follow mode");
  rails_exclusive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pop && !mode_single) |=> !(positive_rail_out && neg_rail_or_violation_out))
    else $error("both rails high in dual-rail mode");
  neg_one_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(recovered_clock_out) && neg_rail_or_violation_out) |-> neg_rail_or_violation_out [*8])
    else $error("negative rail pulse shorter than one period");
  viol_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pop && mode_single && rd_word.viol) |=> neg_rail_or_violation_out [*8])
    else $error("violation not held for one period");
  pos_edge_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(positive_rail_out) |-> ($rose(recovered_clock_out) || !recovered_clock_out && !busy_r))
    else $error("positive rail changed off the clock edge");
  neg_edge_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(neg_rail_or_violation_out) |-> ($rose(recovered_clock_out) || !recovered_clock_out && !busy_r))
    else $error("negative rail changed off the clock edge");
  polarity_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> (wr_word.pos == (sync2_r[SYNC_PLUS] && !sync2_r[SYNC_MINUS]))
             && (wr_word.neg == (sync2_r[SYNC_MINUS] && !sync2_r[SYNC_PLUS])))
    else $error("line polarity mapped wrongly");
  single_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pop && mode_single) |=> positive_rail_out == ($past(rd_word.pos) || $past(rd_word.neg)))
    else $error("single-rail data missing on positive rail");
  pos_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pop && !mode_single && rd_word.pos) |=> positive_rail_out [*8])
    else $error("positive mark not one period on positive rail");
  clock_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(recovered_clock_out) |-> recovered_clock_out [*4] ##1 !recovered_clock_out)
    else $error("recovered clock high phase wrong");
  // equal halves keep the framer's falling-edge sample mid-bit
  clock_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(recovered_clock_out) |-> !recovered_clock_out [*4])
    else $error("recovered clock low phase too short");
  idle_clock_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !busy_r |-> !recovered_clock_out)
    else $error("recovered clock high while output idle");
  buffer_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    count_r <= CW'(DEPTH))
    else $error("buffer count past its depth");
endmodule : lrop_rx

/* lrop_framer.sv */
// framer model that takes the recovered rail data
`timescale 1ns/100ps
module lrop_framer
  import lrop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic recovered_clock_out,
  input wire logic positive_rail_out,
  input wire logic neg_rail_or_violation_out,
  output logic out_ready
);
  lrop_word_t got_q[$];
  int high_cnt;
  int high_len;
  assign out_ready = !stall;
  // high phase of the last recovered clock pulse, in system clock cycles
  always @(posedge sys_clk) begin
    if (recovered_clock_out) begin
      high_cnt++;
    end else if (high_cnt != 0) begin
      high_len = high_cnt;
      high_cnt = 0;
    end
  end
  // mid-bit sample keeps clear of the rail update edge
  always @(negedge recovered_clock_out) begin
    if (rst_n) begin
      got_q.push_back('{pos: positive_rail_out, neg: neg_rail_or_violation_out, viol: 1'b0});
    end
  end
endmodule : lrop_framer

/* test_line_receive_output_port.sv */
// self-checking testbench for the line receive output port
`timescale 1ns/100ps
module test_line_receive_output_port;
  import lrop_pkg::*;
  logic sys_clk, rst_n, line_clk, lp, lm, single, stall, rdy, in_rdy, rclk, pos, nv;
  int err_count, cmp_count, cycles;
  lrop_word_t exp_q[$];
  lrop_rx i_lrop_rx(.sys_clk(sys_clk), .rst_n(rst_n), .line_clk(line_clk), .line_input_plus(lp),
    .line_input_minus(lm), .single_rail_mode(single), .out_ready(rdy), .in_ready_out(in_rdy),
    .recovered_clock_out(rclk), .positive_rail_out(pos), .neg_rail_or_violation_out(nv));
  lrop_framer i_lrop_framer(.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall), .recovered_clock_out(rclk),
    .positive_rail_out(pos), .neg_rail_or_violation_out(nv), .out_ready(rdy));
  ////////////////////////////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(string what, lrop_word_t e, lrop_word_t g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_bit(string what, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  task automatic chk_num(string what, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_num
  // one line bit, data moved while the line clock is low; entry is {plus, minus, exp pos, exp neg}
  task automatic send(logic [3:0] s, logic keep);
    line_clk = 1'b0;
    lp = s[3];
    lm = s[2];
    tick(4);
    line_clk = 1'b1;
    tick(4);
    if (keep) exp_q.push_back('{pos: s[1], neg: s[0], viol: 1'b0});
  endtask : send
  task automatic drain();
    int n;
    line_clk = 1'b0;
    n = 0;
    while (i_lrop_framer.got_q.size() < exp_q.size() && n < 200) begin
      tick(1);
      n++;
    end
    tick(16);
    foreach (exp_q[i]) chk("rail word", exp_q[i], i_lrop_framer.got_q[i]);
    chk_num("word count", 8'(exp_q.size()), 8'(i_lrop_framer.got_q.size()));
    chk_num("clock high cycles", 8'(OUT_HIGH), 8'(i_lrop_framer.high_len));
    exp_q.delete();
    i_lrop_framer.got_q.delete();
  endtask : drain
  ////////////////////////////////////////////////////////////////
  task automatic dual_marks();
    logic [3:0] s[] = '{4'hA, 4'h0, 4'h5, 4'h5, 4'hA, 4'h0, 4'h0, 4'h0, 4'hA};
    single = 1'b0;
    tick(8);
    foreach (s[i]) send(s[i], 1'b1);
    drain();
  endtask : dual_marks
  // violations: repeated polarity, third zero of a run, both inputs high (no mark, so data 0)
  task automatic single_viol();
    logic [3:0] s[] = '{4'h6, 4'h0, 4'h0, 4'h1, 4'h7, 4'hA, 4'h0, 4'h0, 4'h1, 4'h0, 4'hD};
    single = 1'b1;
    tick(8);
    foreach (s[i]) send(s[i], 1'b1);
    drain();
  endtask : single_viol
  // two-entry buffer holds across a stall; a third bit is refused
  task automatic stall_hold();
    single = 1'b0;
    stall = 1'b1;
    tick(8);
    send(4'hA, 1'b1);
    send(4'h5, 1'b1);
    chk_bit("buffer room", 1'b0, in_rdy);
    send(4'hA, 1'b0);
    chk_bit("clock held", 1'b0, rclk);
    stall = 1'b0;
    drain();
  endtask : stall_hold
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {rst_n, line_clk, lp, lm, single, stall} = 6'h0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    dual_marks();
    single_viol();
    stall_hold();
    conclude();
  end
endmodule : test_line_receive_output_port
